// [include/crf_pkg.sv]
// package: constants and carrier types for the cpu register file
`default_nettype none
package crf_pkg;

  // ==========================================================
  // widths and reset values
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam logic [7:0] IDX_HI_RESET = 8'h00;
  localparam logic [15:0] STACK_RESET = 16'h00ff;
  localparam logic [7:0] STACK_LOW_REINIT = 8'hff;
  localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;
  localparam logic [15:0] VEC_HI_ADDR = 16'hfffe;
  localparam logic [15:0] VEC_LO_ADDR = 16'hffff;
  localparam logic [7:0] FLAG_ONES_MASK = 8'h60;
  localparam int unsigned FLAG_V_POS = 7;
  localparam int unsigned FLAG_H_POS = 4;
  localparam int unsigned FLAG_I_POS = 3;
  localparam int unsigned FLAG_N_POS = 2;
  localparam int unsigned FLAG_Z_POS = 1;
  localparam int unsigned FLAG_C_POS = 0;

  // ==========================================================
  // operations on the 8-bit data registers
  typedef enum logic [3:0] {
    CRF_UOP_NONE = 4'h0,
    CRF_UOP_LOAD = 4'h1,
    CRF_UOP_CLR = 4'h2,
    CRF_UOP_INC = 4'h3,
    CRF_UOP_DEC = 4'h4,
    CRF_UOP_COM = 4'h5,
    CRF_UOP_NEG = 4'h6,
    CRF_UOP_LSL = 4'h7,
    CRF_UOP_LSR = 4'h8,
    CRF_UOP_ASR = 4'h9,
    CRF_UOP_ROL = 4'ha,
    CRF_UOP_ROR = 4'hb,
    CRF_UOP_XFER = 4'hc
  } crf_uop_t;

  // stack pointer operations
  typedef enum logic [2:0] {
    CRF_SOP_NONE = 3'h0,
    CRF_SOP_PUSH = 3'h1,
    CRF_SOP_PULL = 3'h2,
    CRF_SOP_ADJUST = 3'h3,
    CRF_SOP_REINIT = 3'h4,
    CRF_SOP_LOAD = 3'h5
  } crf_sop_t;

  // fetch pointer operations
  typedef enum logic [1:0] {
    CRF_POP_NONE = 2'h0,
    CRF_POP_INC = 2'h1,
    CRF_POP_LOAD = 2'h2
  } crf_pop_t;

  // command from the sequencer, one per cycle
  typedef struct packed {
    crf_uop_t accOp;
    logic [7:0] accData;
    crf_uop_t idxLoOp;
    logic [7:0] idxLoData;
    logic idxHiLoad;
    logic [7:0] idxHiData;
    crf_sop_t stackOp;
    logic [15:0] stackData;
    crf_pop_t fetchOp;
    logic [15:0] fetchData;
    logic flagLoad;
    logic [7:0] flagData;
  } crf_cmd_t;

  // registered view of the programmer model
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idxHi;
    logic [7:0] idxLo;
    logic [15:0] stackPointer;
    logic [15:0] fetchPointer;
    logic [7:0] flagRegister;
  } crf_view_t;

endpackage
`default_nettype wire

// [rtl/crf_byte_unit.sv]
// module: one 8-bit data register with unary operations
`timescale 1ns/1ns
`default_nettype none
module crf_byte_unit #(
  parameter int unsigned W = 8
) (
  input wire logic clk_sys,
  input wire logic ce,
  input wire crf_pkg::crf_uop_t op,
  input wire logic [W-1:0] loadData,
  input wire logic [W-1:0] xferData,
  input wire logic carryIn,
  output logic [W-1:0] value,
  output logic carryOut
);

  logic [W-1:0] value_reg;
  logic [W-1:0] value_next;
  logic carry_reg;
  logic carry_next;

  // ==========================================================
  // next value
  // no reset on purpose: contents survive a reset
  always_comb
  begin
    value_next = value_reg;
    carry_next = carry_reg;
    case (op)
      crf_pkg::CRF_UOP_LOAD: value_next = loadData;
      crf_pkg::CRF_UOP_XFER: value_next = xferData;
      crf_pkg::CRF_UOP_CLR: value_next = '0;
      crf_pkg::CRF_UOP_INC: value_next = value_reg + W'(1);
      crf_pkg::CRF_UOP_DEC: value_next = value_reg - W'(1);
      crf_pkg::CRF_UOP_COM: value_next = ~value_reg;
      crf_pkg::CRF_UOP_NEG: value_next = W'(0) - value_reg;
      crf_pkg::CRF_UOP_LSL:
      begin
        value_next = {value_reg[W-2:0], 1'b0};
        carry_next = value_reg[W-1];
      end
      crf_pkg::CRF_UOP_LSR:
      begin
        value_next = {1'b0, value_reg[W-1:1]};
        carry_next = value_reg[0];
      end
      crf_pkg::CRF_UOP_ASR:
      begin
        value_next = {value_reg[W-1], value_reg[W-1:1]};
        carry_next = value_reg[0];
      end
      crf_pkg::CRF_UOP_ROL:
      begin
        value_next = {value_reg[W-2:0], carryIn};
        carry_next = value_reg[W-1];
      end
      crf_pkg::CRF_UOP_ROR:
      begin
        value_next = {carryIn, value_reg[W-1:1]};
        carry_next = value_reg[0];
      end
      default: value_next = value_reg;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (ce)
    begin
      value_reg <= value_next;
      carry_reg <= carry_next;
    end
  end

  assign value = value_reg;
  assign carryOut = carry_reg;

endmodule
`default_nettype wire

// [rtl/crf_register_file.sv]
// module: programmer-visible cpu register set
//
// Overview of operation
// - 8-bit accumulator feeds the alu and takes results, loads and stores.
// - reset leaves the accumulator contents unchanged.
// - index pointer is two 8-bit halves, upper gives bits 15:8.
// - indexed addressing always uses the full 16-bit index pair.
// - some instructions touch only the lower index byte, upper untouched.
// - lower index byte is a general data register with unary ops.
// - reset clears the upper index byte, lower byte keeps its value.
// - 16-bit stack pointer addresses the next free stack location.
// - calls push return address; interrupts push address and registers.
// - stack adjust adds a sign-extended 8-bit immediate to the pointer.
// - reset loads the stack pointer with 0x00ff.
// - stack low reinit changes only the stack pointer's low byte.
// - registers have no memory address, reached only by instructions.
// - direct operands sit in page zero, upper address byte zero.
// - 16-bit fetch pointer increments per fetch, loads on change of flow.
// - reset loads the fetch pointer from the top two bytes, high first.
// - flag register holds mask and five flags, bits 6 and 5 read one.
`timescale 1ns/1ns
`default_nettype none
module crf_register_file #(
  parameter int unsigned DW = crf_pkg::BYTE_W,
  parameter int unsigned AW = crf_pkg::WORD_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire crf_pkg::crf_cmd_t cmd,
  input wire logic [7:0] adjustImm,
  input wire logic [7:0] directOffset,
  input wire logic [7:0] vectorByte,
  input wire logic vectorValid,
  output crf_pkg::crf_view_t view,
  output logic [15:0] indexAddr,
  output logic [15:0] directAddr,
  output logic [15:0] vectorAddr,
  output logic vectorReq,
  output logic resetDone
);

  // ==========================================================
  // reset vector sequencer
  // gray path: hi fetch -> lo fetch -> run
  typedef enum logic [1:0] {
    CRF_ST_VEC_HI = 2'b00,
    CRF_ST_VEC_LO = 2'b01,
    CRF_ST_RUN = 2'b11
  } crf_state_t;

  crf_state_t state_reg;
  crf_state_t state_next;

  // ==========================================================
  // storage declarations
  logic [7:0] accValue;
  logic [7:0] idxLoValue;
  logic [7:0] idxHi_reg;
  logic [7:0] idxHi_next;
  logic [15:0] stack_reg;
  logic [15:0] stack_next;
  logic [15:0] fetch_reg;
  logic [15:0] fetch_next;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [15:0] indexAddr_reg;
  logic [15:0] directAddr_reg;
  logic [15:0] vectorAddr_reg;
  logic vectorReq_reg;
  logic resetDone_reg;

  // operations only run once the vector is in
  wire running = (state_reg == CRF_ST_RUN);
  wire opCe = ce & running;
  wire crf_pkg::crf_uop_t accOpGated = running ? cmd.accOp : crf_pkg::CRF_UOP_NONE;
  wire crf_pkg::crf_uop_t idxOpGated = running ? cmd.idxLoOp : crf_pkg::CRF_UOP_NONE;
  wire carryFlag = flag_reg[crf_pkg::FLAG_C_POS];

  // ==========================================================
  // accumulator and lower index byte, neither one reset
  // transfers swap through the xfer port: each takes the other's value
  crf_byte_unit #(
    .W(DW)
  ) uAcc (
    .clk_sys(clk_sys),
    .ce(ce),
    .op(accOpGated),
    .loadData(cmd.accData),
    .xferData(idxLoValue),
    .carryIn(carryFlag),
    .value(accValue),
    .carryOut()
  );

  crf_byte_unit #(
    .W(DW)
  ) uIdxLo (
    .clk_sys(clk_sys),
    .ce(ce),
    .op(idxOpGated),
    .loadData(cmd.idxLoData),
    .xferData(accValue),
    .carryIn(carryFlag),
    .value(idxLoValue),
    .carryOut()
  );

  // ==========================================================
  // upper index byte: only its own load touches it
  assign idxHi_next = cmd.idxHiLoad ? cmd.idxHiData : idxHi_reg;

  // ==========================================================
  // stack pointer next value
  // push moves down, pull moves up; pointer always at next free byte
  wire [15:0] adjustExt = {{8{adjustImm[7]}}, adjustImm};
  wire [15:0] stackPushed = stack_reg - 16'h0001;
  wire [15:0] stackPulled = stack_reg + 16'h0001;
  wire [15:0] stackAdjusted = stack_reg + adjustExt;
  wire [15:0] stackReinit = {stack_reg[15:8], crf_pkg::STACK_LOW_REINIT};

  always_comb
  begin
    case (cmd.stackOp)
      crf_pkg::CRF_SOP_PUSH: stack_next = stackPushed;
      crf_pkg::CRF_SOP_PULL: stack_next = stackPulled;
      crf_pkg::CRF_SOP_ADJUST: stack_next = stackAdjusted;
      crf_pkg::CRF_SOP_REINIT: stack_next = stackReinit;
      crf_pkg::CRF_SOP_LOAD: stack_next = cmd.stackData;
      default: stack_next = stack_reg;
    endcase
  end

  // ==========================================================
  // fetch pointer next value, vector bytes high first
  always_comb
  begin
    fetch_next = fetch_reg;
    case (state_reg)
      CRF_ST_VEC_HI:
        if (vectorValid)
          fetch_next = {vectorByte, fetch_reg[7:0]};
      CRF_ST_VEC_LO:
        if (vectorValid)
          fetch_next = {fetch_reg[15:8], vectorByte};
      CRF_ST_RUN:
        case (cmd.fetchOp)
          crf_pkg::CRF_POP_INC: fetch_next = fetch_reg + 16'h0001;
          crf_pkg::CRF_POP_LOAD: fetch_next = cmd.fetchData;
          default: fetch_next = fetch_reg;
        endcase
      default: fetch_next = fetch_reg;
    endcase
  end

  // sequencer transitions
  always_comb
  begin
    case (state_reg)
      CRF_ST_VEC_HI: state_next = vectorValid ? CRF_ST_VEC_LO : CRF_ST_VEC_HI;
      CRF_ST_VEC_LO: state_next = vectorValid ? CRF_ST_RUN : CRF_ST_VEC_LO;
      CRF_ST_RUN: state_next = CRF_ST_RUN;
      default: state_next = CRF_ST_VEC_HI;
    endcase
  end

  // ==========================================================
  // flag register: fixed ones forced on every write
  assign flag_next = cmd.flagLoad ? (cmd.flagData | crf_pkg::FLAG_ONES_MASK) : flag_reg;

  // ==========================================================
  // address outputs
  // registered so every output leaves a flop; index and direct addresses lag one cycle, vector outputs are built from the next state
  wire [15:0] indexAddrNext = {idxHi_reg, idxLoValue};
  wire [15:0] directAddrNext = {crf_pkg::DIRECT_PAGE_HI, directOffset};
  wire [15:0] vectorAddrNext = (state_next == CRF_ST_VEC_LO) ? crf_pkg::VEC_LO_ADDR
                                                              : crf_pkg::VEC_HI_ADDR;
  wire vectorReqNext = (state_next != CRF_ST_RUN);

  // ==========================================================
  // reset-bearing state
  // accumulator and lower index live in the unit without reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      idxHi_reg <= crf_pkg::IDX_HI_RESET;
      stack_reg <= crf_pkg::STACK_RESET;
      fetch_reg <= '0;
      flag_reg <= crf_pkg::FLAG_ONES_MASK;
      state_reg <= CRF_ST_VEC_HI;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      fetch_reg <= fetch_next;
      if (running)
      begin
        idxHi_reg <= idxHi_next;
        stack_reg <= stack_next;
        flag_reg <= flag_next;
      end
    end
  end

  // ==========================================================
  // output flops
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      indexAddr_reg <= '0;
      directAddr_reg <= '0;
      vectorAddr_reg <= crf_pkg::VEC_HI_ADDR;
      vectorReq_reg <= 1'b1;
      resetDone_reg <= 1'b0;
    end
    else if (ce)
    begin
      indexAddr_reg <= indexAddrNext;
      directAddr_reg <= directAddrNext;
      vectorAddr_reg <= vectorAddrNext;
      vectorReq_reg <= vectorReqNext;
      resetDone_reg <= ~vectorReqNext;
    end
  end

  // ==========================================================
  // register view: no memory-mapped path exists anywhere
  // one driver for the whole carrier, not one per field
  assign view = '{
    acc: accValue,
    idxHi: idxHi_reg,
    idxLo: idxLoValue,
    stackPointer: stack_reg,
    fetchPointer: fetch_reg,
    flagRegister: flag_reg
  };
  assign indexAddr = indexAddr_reg;
  assign directAddr = directAddr_reg;
  assign vectorAddr = vectorAddr_reg;
  assign vectorReq = vectorReq_reg;
  assign resetDone = resetDone_reg;

endmodule
`default_nettype wire

// [tb/crf_register_file_props.sv]
// checker: concurrent properties on the register file ports
`timescale 1ns/1ns
`default_nettype none
module crf_register_file_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire crf_pkg::crf_cmd_t cmd,
  input wire logic [7:0] adjustImm,
  input wire logic [7:0] directOffset,
  input wire logic [7:0] vectorByte,
  input wire logic vectorValid,
  input wire crf_pkg::crf_view_t view,
  input wire logic [15:0] indexAddr,
  input wire logic [15:0] directAddr,
  input wire logic [15:0] vectorAddr,
  input wire logic vectorReq,
  input wire logic resetDone
);
  // ==========================================================
  // helpers
  // low index byte has no reset value, so pair checks wait for a load
  logic idxSeen_reg;
  wire run = resetDone & ce;
  wire [15:0] stackNow = view.stackPointer;
  wire [15:0] immExt = {{8{adjustImm[7]}}, adjustImm};
  wire [15:0] pairNow = {view.idxHi, view.idxLo};
  wire [7:0] fetchHi = view.fetchPointer[15:8];
  wire [7:0] flagIn = cmd.flagData;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      idxSeen_reg <= 1'b0;
    else if (run && cmd.idxLoOp == crf_pkg::CRF_UOP_LOAD)
      idxSeen_reg <= 1'b1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // properties
  adjust_sum_a: assert property (run && cmd.stackOp == crf_pkg::CRF_SOP_ADJUST
    |=> stackNow == $past(stackNow) + $past(immExt)) else $error("stack adjust sum wrong");
  reinit_low_a: assert property (run && cmd.stackOp == crf_pkg::CRF_SOP_REINIT
    |=> stackNow == ($past(stackNow) | 16'h00ff)) else $error("stack reinit wrong");
  reset_value_a: assert property ($fell(rst)
    |-> view.idxHi == 8'h00 && stackNow == 16'h00ff) else $error("reset values wrong");
  index_pair_a: assert property (idxSeen_reg && $past(idxSeen_reg) && $past(ce)
    |-> indexAddr == $past(pairNow)) else $error("index address wrong");
  direct_page_a: assert property (resetDone && $past(run)
    |-> directAddr == {8'h00, $past(directOffset)}) else $error("direct address wrong");
  // sampled rst keeps the release edge out: the design is still in reset there
  vector_high_a: assert property (!rst && vectorReq && vectorAddr == 16'hfffe
    && vectorValid && ce |=> vectorAddr == 16'hffff && fetchHi == $past(vectorByte))
    else $error("vector high wrong");
  vector_low_a: assert property (!rst && vectorReq && vectorAddr == 16'hffff
    && vectorValid && ce |=> !vectorReq && resetDone
    && view.fetchPointer[7:0] == $past(vectorByte) && $stable(fetchHi))
    else $error("vector low wrong");
  flag_ones_a: assert property (run && cmd.flagLoad
    |=> view.flagRegister == ($past(flagIn) | 8'h60)) else $error("flag load wrong");
endmodule
bind crf_register_file crf_register_file_props u_crf_register_file_props (.clk_sys, .rst, .ce,
  .cmd, .adjustImm, .directOffset, .vectorByte, .vectorValid, .view, .indexAddr, .directAddr,
  .vectorAddr, .vectorReq, .resetDone);
`default_nettype wire

// [tb/crf_register_file_tb.sv]
// testbench: directed scenarios for the cpu register file
`timescale 1ns/1ns
`default_nettype none
module crf_register_file_tb;
  // ==========================================================
  // signals and instances
  localparam logic [15:0] VEC = 16'h1234;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic slow = 1'b1;
  logic [7:0] adjustImm = 8'h00;
  logic [7:0] directOffset = 8'h00;
  crf_pkg::crf_cmd_t cmd = '0;
  crf_pkg::crf_cmd_t c;
  crf_pkg::crf_view_t view;
  logic [15:0] indexAddr, directAddr, vectorAddr;
  logic [7:0] vectorByte;
  logic vectorValid, vectorReq, resetDone;
  int n_mismatch = 0;
  int n_tests = 0;
  crf_register_file u_crf_register_file (.clk_sys, .rst, .ce, .cmd, .adjustImm, .directOffset,
    .vectorByte, .vectorValid, .view, .indexAddr, .directAddr, .vectorAddr, .vectorReq,
    .resetDone);
  crf_vector_mem #(.VEC(VEC)) u_crf_vector_mem (.clk_sys, .rst, .slow, .vectorReq, .vectorAddr,
    .vectorByte, .vectorValid);
  // free running clock
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // command goes out on an edge and is taken at the next one
  task automatic go(input crf_pkg::crf_cmd_t k);
    @(posedge clk_sys);
    cmd <= k;
  endtask
  task automatic settle();
    go('0);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_vector();
    int k = 0;
    chk("stack", 16'h00ff, view.stackPointer);
    chk("idxHi", 16'h0000, {8'h00, view.idxHi});
    while (resetDone !== 1'b1 && k < 20)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    #1;
    chk("fetch", VEC, view.fetchPointer);
    chk("resetDone", 16'h0001, {15'h0, resetDone});
    chk("vectorReq", 16'h0000, {15'h0, vectorReq});
    c = '0;
    c.fetchOp = crf_pkg::CRF_POP_INC;
    go(c);
    settle();
    chk("fetch", VEC + 16'h0001, view.fetchPointer);
    $display("test vector done");
  endtask
  // ops CLR..ROR are codes 2..11; carry is set so rotates differ from shifts
  task automatic t_data();
    logic [7:0] expA[10] = '{8'h00, 8'h17, 8'h15, 8'he9, 8'hea, 8'h2c, 8'h0b, 8'h0b, 8'h2d, 8'h8b};
    logic [7:0] expX[10] = '{8'h00, 8'h97, 8'h95, 8'h69, 8'h6a, 8'h2c, 8'h4b, 8'hcb, 8'h2d, 8'hcb};
    c = '0;
    c.flagLoad = 1'b1;
    c.flagData = 8'h01;
    c.idxHiLoad = 1'b1;
    c.idxHiData = 8'hab;
    go(c);
    for (int i = 0; i < 10; i++)
    begin
      c = '0;
      c.accOp = crf_pkg::CRF_UOP_LOAD;
      c.idxLoOp = crf_pkg::CRF_UOP_LOAD;
      c.accData = 8'h16;
      c.idxLoData = 8'h96;
      go(c);
      c.accOp = crf_pkg::crf_uop_t'(i + 2);
      c.idxLoOp = crf_pkg::crf_uop_t'(i + 2);
      go(c);
      settle();
      chk("acc", {8'h00, expA[i]}, {8'h00, view.acc});
      chk("idxLo", {8'h00, expX[i]}, {8'h00, view.idxLo});
    end
    chk("flags", 16'h0061, {8'h00, view.flagRegister});
    settle();
    chk("index", 16'habcb, indexAddr);
    c = '0;
    c.accOp = crf_pkg::CRF_UOP_XFER;
    c.idxLoOp = crf_pkg::CRF_UOP_XFER;
    go(c);
    settle();
    chk("swap", 16'hcb8b, {view.acc, view.idxLo});
    $display("test data done");
  endtask
  // stack codes: load, adjust, adjust, reinit, push, pull issued back to back
  task automatic t_stack();
    logic [2:0] ops[6] = '{3'h5, 3'h3, 3'h3, 3'h4, 3'h1, 3'h2};
    logic [7:0] imm[6] = '{8'h00, 8'hfe, 8'h7f, 8'h00, 8'h00, 8'h00};
    logic [15:0] exp[6] = '{16'h1200, 16'h11fe, 16'h127d, 16'h12ff, 16'h12fe, 16'h12ff};
    for (int i = 0; i < 6; i++)
    begin
      c = '0;
      c.stackOp = crf_pkg::crf_sop_t'(ops[i]);
      c.stackData = 16'h1200;
      go(c);
      adjustImm <= imm[i];
      #1;
      if (i > 0)
        chk("stack", exp[i-1], view.stackPointer);
    end
    settle();
    chk("stack", exp[5], view.stackPointer);
    go('0);
    directOffset <= 8'h5a;
    settle();
    settle();
    chk("direct", 16'h005a, directAddr);
    $display("test stack done");
  endtask
  // low enable holds a pending command off, then it lands in one edge
  task automatic t_freeze();
    c = '0;
    c.fetchOp = crf_pkg::CRF_POP_LOAD;
    c.fetchData = 16'h4321;
    c.stackOp = crf_pkg::CRF_SOP_PUSH;
    c.accOp = crf_pkg::CRF_UOP_INC;
    @(posedge clk_sys);
    ce <= 1'b0;
    cmd <= c;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("fetch", VEC + 16'h0001, view.fetchPointer);
    chk("stack", 16'h12ff, view.stackPointer);
    chk("acc", 16'h00cb, {8'h00, view.acc});
    @(posedge clk_sys);
    ce <= 1'b1;
    settle();
    chk("fetch", 16'h4321, view.fetchPointer);
    chk("stack", 16'h12fe, view.stackPointer);
    chk("acc", 16'h00cc, {8'h00, view.acc});
    $display("test freeze done");
  endtask
  task automatic t_mid_reset();
    logic [15:0] was;
    was = {view.acc, view.idxLo};
    @(posedge clk_sys);
    rst <= 1'b1;
    slow <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("accIdxLo", was, {view.acc, view.idxLo});
    t_vector();
    $display("test mid reset done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    t_vector();
    t_data();
    t_stack();
    t_freeze();
    t_mid_reset();
    tally_and_finish();
  end
  // about eighty times the expected run
  initial
  begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [tb/crf_vector_mem.sv]
// partner: memory side that answers the reset vector fetch
`timescale 1ns/1ns
`default_nettype none
module crf_vector_mem #(
  parameter logic [15:0] VEC = 16'h1234
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic slow,
  input wire logic vectorReq,
  input wire logic [15:0] vectorAddr,
  output logic [7:0] vectorByte,
  output logic vectorValid
);
  // ==========================================================
  // answer logic
  // slow mode answers every other cycle; an idle bus shows inverted data, never a stale copy
  logic stall_reg;
  logic [7:0] lastByte_reg;
  wire [7:0] word = (vectorAddr == 16'hfffe) ? VEC[15:8] : VEC[7:0];
  assign vectorValid = vectorReq & ~stall_reg;
  assign vectorByte = vectorValid ? word : ~lastByte_reg;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      stall_reg <= 1'b0;
    else
      stall_reg <= slow & ~stall_reg;
  end
  // remember what was last driven
  always_ff @(posedge clk_sys)
  begin
    if (vectorValid)
      lastByte_reg <= vectorByte;
  end
endmodule
`default_nettype wire
